//--- design/fdx_pkg.sv
// Purpose: Shared constants for the chained FIFO pin controller.
// Assumes: pclk runs at 100 MHz.
// Notes: Times are in ns; cycle counts are derived from them.
package fdx_pkg;
  // Clock and data widths.
  localparam int CLK_NS = 10;
  localparam int DATA_W = 9;
  localparam int CNT_W = 8;
  localparam int SYNC_LAT = 3;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] RDATA_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // Control fields.
  localparam int CTRL_CHAIN_BIT = 0;
  localparam int CTRL_FIRST_BIT = 1;

  // Command fields, write one to act.
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_REPLAY_BIT = 3;
  localparam int CMD_CLEAR_BIT = 4;

  // Status fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_HALF_BIT = 3;
  localparam int ST_RDONE_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;

  // Reset values.
  localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;

  // Pin timing in ns.
  localparam int RST_PULSE_NS = 20;
  localparam int RST_REC_NS = 10;
  localparam int WR_PULSE_NS = 20;
  localparam int WR_REC_NS = 10;
  localparam int RD_PULSE_NS = 20;
  localparam int RT_PULSE_NS = 20;
  localparam int FLAG_VALID_NS = 30;

  // Least times round up to whole cycles.
  localparam logic [CNT_W-1:0] RST_PULSE_CNT = CNT_W'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RST_REC_CNT = CNT_W'((RST_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WR_PULSE_CNT = CNT_W'((WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WR_REC_CNT = CNT_W'((WR_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RD_LOW_CNT =
    CNT_W'((RD_PULSE_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  localparam logic [CNT_W-1:0] RT_PULSE_CNT = CNT_W'((RT_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SETTLE_CNT =
    CNT_W'((FLAG_VALID_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  localparam logic [CNT_W-1:0] ONE_CNT = 8'h01;

  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    FDX_IDLE = 9'h001,
    FDX_RST_LOW = 9'h002,
    FDX_RST_REC = 9'h004,
    FDX_WR_SETUP = 9'h008,
    FDX_WR_LOW = 9'h010,
    FDX_WR_REC = 9'h020,
    FDX_RD_LOW = 9'h040,
    FDX_RT_LOW = 9'h080,
    FDX_SETTLE = 9'h100
  } fdx_state_type;
endpackage

//--- design/fdx_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to pclk.
// Notes: The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module fdx_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pins and filtered result.
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // A zero width cannot be served.
  if (WIDTH < 1) begin : g_bad_width
    $error("fdx_sync width must be at least one");
  end

  // One three-flop chain per bit.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    logic out_q;
    logic next_out;

    // Each bit keeps its own result flop, so every process has its own target.
    assign dout[i] = out_q;

    // Stage one feeds stage two only, so metastability never reaches logic.
    always_comb begin
      next_out = (s2 == s3) ? s3 : out_q;
    end

    // Registers of this bit.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        out_q <= 1'b0;
      end else begin
        s1 <= din[i];
        s2 <= s1;
        s3 <= s2;
        out_q <= next_out;
      end
    end
  end
endmodule // fdx_sync

//--- design/fdx_ctrl.sv
// Purpose: APB-controlled sequencer that drives a chained FIFO through its pins.
// Assumes: Flag and data pins are asynchronous and pass fdx_sync.
// Notes: One pin operation at a time; pin commands while busy are refused.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Pulse reset before the first write.
// - Strobes high around reset release and recovery.
// - Write data stable around rising strobe.
// - Strobes held high during replay pulse.
// - Shared pin: replay, or first-device mark.
// - Chain input low selects single device.
// - Board combines chained empty and full flags.
module fdx_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device control pins.
  output logic reset_in_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic replay_n,
  output logic chain_in_n,
  output logic [fdx_pkg::DATA_W-1:0] write_data,
  // Device status pins.
  input wire logic [fdx_pkg::DATA_W-1:0] read_data,
  input wire logic buffer_full_n,
  input wire logic buffer_empty_n,
  input wire logic half_level_n
);
  // The offsets need at least five address bits.
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("fdx_ctrl address width must be 5 to 8");
  end

  localparam int DW = fdx_pkg::DATA_W;

  fdx_pkg::fdx_state_type state, next_state;
  logic [fdx_pkg::CNT_W-1:0] cnt, next_cnt;
  logic chain_mode, next_chain_mode;
  logic first_dev, next_first_dev;
  logic reset_done, next_reset_done;
  logic refused, next_refused;
  logic [DW-1:0] wdata_reg, next_wdata_reg;
  logic [DW-1:0] rdata_reg, next_rdata_reg;
  logic next_reset_in_n, next_write_strobe_n, next_read_strobe_n, next_replay_n;
  logic next_chain_in_n;
  logic [DW-1:0] next_write_data;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [DW+2:0] sync_out;
  logic full_s, empty_s, half_s;
  logic [7:0] addr;
  logic wr_take, rd_start, busy;

  // Device outputs are asynchronous; in a chain the board combines the flags first.
  fdx_sync #(.WIDTH(DW + 3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({half_level_n, buffer_empty_n, buffer_full_n, read_data}),
    .dout(sync_out)
  );

  // Filtered flags turned to active-high meaning.
  assign full_s = !sync_out[DW];
  assign empty_s = !sync_out[DW+1];
  assign half_s = !sync_out[DW+2];
  assign addr = 8'(paddr);
  assign busy = (state != fdx_pkg::FDX_IDLE);
  assign wr_take = psel && penable && pready && pwrite;
  assign rd_start = psel && penable && !pready && !pwrite;

  // Register file, APB answer and pin sequencer.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_chain_mode = chain_mode;
    next_first_dev = first_dev;
    next_reset_done = reset_done;
    next_refused = refused;
    next_wdata_reg = wdata_reg;
    next_rdata_reg = rdata_reg;
    next_reset_in_n = reset_in_n;
    next_write_strobe_n = write_strobe_n;
    next_read_strobe_n = read_strobe_n;
    next_write_data = write_data;
    // One wait state lets the read data come from a register.
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (rd_start) begin
      case (addr)
        fdx_pkg::CTRL_OFF: next_prdata = {30'h0, first_dev, chain_mode};
        fdx_pkg::CMD_OFF: next_prdata = 32'h0;
        fdx_pkg::WDATA_OFF: next_prdata = {23'h0, wdata_reg};
        fdx_pkg::RDATA_OFF: next_prdata = {23'h0, rdata_reg};
        fdx_pkg::STATUS_OFF: next_prdata = {26'h0, refused, reset_done, half_s, empty_s,
                                            full_s, busy};
        default: begin
          next_prdata = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && !pready) begin
      next_pslverr = !(addr == fdx_pkg::CTRL_OFF || addr == fdx_pkg::CMD_OFF ||
                       addr == fdx_pkg::WDATA_OFF || addr == fdx_pkg::RDATA_OFF ||
                       addr == fdx_pkg::STATUS_OFF);
    end
    if (wr_take && addr == fdx_pkg::CTRL_OFF) begin
      next_chain_mode = pwdata[fdx_pkg::CTRL_CHAIN_BIT];
      next_first_dev = pwdata[fdx_pkg::CTRL_FIRST_BIT];
    end
    if (wr_take && addr == fdx_pkg::WDATA_OFF) begin
      next_wdata_reg = pwdata[DW-1:0];
    end
    if (wr_take && addr == fdx_pkg::CMD_OFF && pwdata[fdx_pkg::CMD_CLEAR_BIT]) begin
      next_refused = 1'b0;
    end
    // Sequencer; refusals below come after the clear, so a set wins.
    case (state)
      fdx_pkg::FDX_IDLE: begin
        if (wr_take && addr == fdx_pkg::CMD_OFF) begin
          if (pwdata[fdx_pkg::CMD_RESET_BIT]) begin
            next_reset_in_n = 1'b0;
            next_state = fdx_pkg::FDX_RST_LOW;
            next_cnt = fdx_pkg::RST_PULSE_CNT;
          end else if (pwdata[fdx_pkg::CMD_REPLAY_BIT]) begin
            if (chain_mode) begin
              next_refused = 1'b1;
            end else begin
              next_state = fdx_pkg::FDX_RT_LOW;
              next_cnt = fdx_pkg::RT_PULSE_CNT;
            end
          end else if (pwdata[fdx_pkg::CMD_WRITE_BIT]) begin
            // A full device would ignore the strobe, so the word is refused here.
            if (!reset_done || full_s) begin
              next_refused = 1'b1;
            end else begin
              next_write_data = wdata_reg;
              next_state = fdx_pkg::FDX_WR_SETUP;
              next_cnt = fdx_pkg::ONE_CNT;
            end
          end else if (pwdata[fdx_pkg::CMD_READ_BIT]) begin
            if (empty_s) begin
              next_refused = 1'b1;
            end else begin
              next_read_strobe_n = 1'b0;
              next_state = fdx_pkg::FDX_RD_LOW;
              next_cnt = fdx_pkg::RD_LOW_CNT;
            end
          end
        end
      end
      fdx_pkg::FDX_RST_LOW: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_reset_in_n = 1'b1;
          next_state = fdx_pkg::FDX_RST_REC;
          next_cnt = fdx_pkg::RST_REC_CNT;
        end
      end
      fdx_pkg::FDX_RST_REC: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_reset_done = 1'b1;
          next_state = fdx_pkg::FDX_SETTLE;
          next_cnt = fdx_pkg::SETTLE_CNT;
        end
      end
      fdx_pkg::FDX_WR_SETUP: begin
        next_write_strobe_n = 1'b0;
        next_state = fdx_pkg::FDX_WR_LOW;
        next_cnt = fdx_pkg::WR_PULSE_CNT;
      end
      fdx_pkg::FDX_WR_LOW: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_write_strobe_n = 1'b1;
          next_state = fdx_pkg::FDX_WR_REC;
          next_cnt = fdx_pkg::WR_REC_CNT;
        end
      end
      fdx_pkg::FDX_WR_REC: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_state = fdx_pkg::FDX_SETTLE;
          next_cnt = fdx_pkg::SETTLE_CNT;
        end
      end
      fdx_pkg::FDX_RD_LOW: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        // The bus is only driven while the strobe is low, so sample before raising it.
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_rdata_reg = sync_out[DW-1:0];
          next_read_strobe_n = 1'b1;
          next_state = fdx_pkg::FDX_SETTLE;
          next_cnt = fdx_pkg::SETTLE_CNT;
        end
      end
      fdx_pkg::FDX_RT_LOW: begin
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_state = fdx_pkg::FDX_SETTLE;
          next_cnt = fdx_pkg::SETTLE_CNT;
        end
      end
      fdx_pkg::FDX_SETTLE: begin
        // Waiting here lets flags settle and pass the filter before the next check.
        next_cnt = cnt - fdx_pkg::ONE_CNT;
        if (cnt == fdx_pkg::ONE_CNT) begin
          next_state = fdx_pkg::FDX_IDLE;
        end
      end
      default: begin
        next_state = fdx_pkg::FDX_IDLE;
        next_cnt = '0;
      end
    endcase
    // Busy pin commands are refused and leave the pins alone.
    if (busy && wr_take && addr == fdx_pkg::CMD_OFF && |pwdata[3:0]) begin
      next_refused = 1'b1;
    end
    // Shared pin: replay pulse in single mode, first-device mark in chain mode.
    next_replay_n = next_chain_mode ? !next_first_dev : 1'b1;
    if (next_state == fdx_pkg::FDX_RT_LOW) begin
      next_replay_n = 1'b0;
    end
    // Low selects single mode; in chain mode the pin is released for the chain link.
    next_chain_in_n = next_chain_mode;
  end

  // Registers of the whole block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fdx_pkg::FDX_IDLE;
      cnt <= '0;
      chain_mode <= 1'b0;
      first_dev <= 1'b0;
      reset_done <= 1'b0;
      refused <= 1'b0;
      wdata_reg <= fdx_pkg::DATA_RESET;
      rdata_reg <= fdx_pkg::DATA_RESET;
      reset_in_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      replay_n <= 1'b1;
      chain_in_n <= 1'b0;
      write_data <= fdx_pkg::DATA_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      chain_mode <= next_chain_mode;
      first_dev <= next_first_dev;
      reset_done <= next_reset_done;
      refused <= next_refused;
      wdata_reg <= next_wdata_reg;
      rdata_reg <= next_rdata_reg;
      reset_in_n <= next_reset_in_n;
      write_strobe_n <= next_write_strobe_n;
      read_strobe_n <= next_read_strobe_n;
      replay_n <= next_replay_n;
      chain_in_n <= next_chain_in_n;
      write_data <= next_write_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Checks on the pins this controller drives.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  no_early_write_a: assert property (!reset_done |-> write_strobe_n)
    else $error("write strobe before device reset");
  reset_strobes_a: assert property (!reset_in_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during reset");
  reset_recover_a: assert property ($rose(reset_in_n) |-> (write_strobe_n && read_strobe_n)[*3])
    else $error("strobe moved inside reset recovery");
  data_stable_a: assert property (!write_strobe_n |=> $stable(write_data))
    else $error("write data moved around strobe");
  write_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*2])
    else $error("write pulse too short");
  replay_strobes_a: assert property (!replay_n && !chain_mode |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during replay");
  write_full_a: assert property ($fell(write_strobe_n) |-> !$past(full_s, 2))
    else $error("write started on full device");
  read_empty_a: assert property ($fell(read_strobe_n) |-> !$past(empty_s))
    else $error("read started on empty device");
  chain_pin_a: assert property (chain_mode && !first_dev |-> replay_n)
    else $error("shared pin low on later chained device");

  write_seen_c: cover property ($rose(write_strobe_n));
  read_seen_c: cover property ($rose(read_strobe_n) ##1 busy);
  reset_seen_c: cover property ($rose(reset_in_n));
  replay_seen_c: cover property ($fell(replay_n) && !chain_mode);
endmodule // fdx_ctrl

//--- verification/fdx_fifo_model.sv
// Purpose: Behavioural model of one FIFO channel seen through its pins.
// Assumes: Depth is a small parameter; flags follow the fill count.
// Notes: Undriven data lines show the inverse of the last word read.
`timescale 1ns/1ps
module fdx_fifo_model #(
  parameter int DEPTH = 8
) (
  // Control pins.
  input wire logic reset_in_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic replay_n,
  input wire logic chain_in_n,
  input wire logic [fdx_pkg::DATA_W-1:0] write_data,
  // Status pins and breach count.
  output logic [fdx_pkg::DATA_W-1:0] read_data,
  output logic buffer_full_n,
  output logic buffer_empty_n,
  output logic half_level_n,
  output int rule_errs
);
  logic [fdx_pkg::DATA_W-1:0] mem [DEPTH];
  logic [fdx_pkg::DATA_W-1:0] last = '0;
  int wp = 0;
  int rp = 0;
  int count = 0;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  logic was_reset = 1'b0;
  initial begin
    rule_errs = 0;
    half_level_n = 1'b1;
  end
  // Flags come straight from the fill count.
  assign buffer_empty_n = (count != 0);
  assign buffer_full_n = (count != DEPTH);
  // A released bus is not held, so stale data cannot pass for a read.
  assign read_data = (!read_strobe_n && rd_ok) ? last : ~last;
  // Reset rewinds both pointers.
  always @(negedge reset_in_n) begin
    wp = 0;
    rp = 0;
    count = 0;
    half_level_n = 1'b1;
    was_reset = 1'b1;
  end
  // Strobes must be quiet when reset is released.
  always @(posedge reset_in_n) begin
    if (was_reset && !(write_strobe_n && read_strobe_n)) rule_errs++;
  end
  // A write is taken at the falling strobe unless full.
  always @(negedge write_strobe_n) begin
    if (!was_reset || (!replay_n && !chain_in_n)) rule_errs++;
    // A chained device answers only while it holds the turn; the first-load one does.
    wr_ok = reset_in_n && buffer_full_n && (!chain_in_n || !replay_n);
    if (wr_ok && !chain_in_n && count >= DEPTH / 2) half_level_n = 1'b0;
  end
  // Data is stored at the rising strobe.
  always @(posedge write_strobe_n) begin
    if (wr_ok) begin
      mem[wp] = write_data;
      wp = (wp + 1) % DEPTH;
      count++;
      wr_ok = 1'b0;
      // In chain mode the shared output pulses once the last location is written.
      if (chain_in_n && wp == 0) begin
        half_level_n = 1'b0;
        #20 half_level_n = 1'b1;
      end
    end
  end
  // A read is taken at the falling strobe unless empty.
  always @(negedge read_strobe_n) begin
    if (!replay_n && !chain_in_n) rule_errs++;
    rd_ok = reset_in_n && buffer_empty_n && (!chain_in_n || !replay_n);
    if (rd_ok) last = mem[rp];
  end
  // The read pointer moves when the strobe rises.
  always @(posedge read_strobe_n) begin
    if (rd_ok) begin
      rp = (rp + 1) % DEPTH;
      count--;
      rd_ok = 1'b0;
      if (!chain_in_n && count <= DEPTH / 2) half_level_n = 1'b1;
    end
  end
  // Replay rewinds the read pointer in single mode only.
  always @(negedge replay_n) begin
    if (was_reset && !(write_strobe_n && read_strobe_n)) rule_errs++;
    if (!chain_in_n) begin
      rp = 0;
      count = wp;
      half_level_n = !(count > DEPTH / 2);
    end
  end
endmodule // fdx_fifo_model

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the FIFO pin controller.
// Assumes: APB answers after one wait state; a model stands at the pins.
// Notes: Each scenario drives the block and judges the result itself.
`timescale 1ns/1ps
module tb_top;
  localparam int DEPTH = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic reset_in_n, write_strobe_n, read_strobe_n, replay_n, chain_in_n;
  logic [fdx_pkg::DATA_W-1:0] write_data, read_data;
  logic buffer_full_n, buffer_empty_n, half_level_n;
  int model_errs;
  int fails = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;
  fdx_ctrl u_fdx_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_in_n(reset_in_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
    .write_data(write_data), .read_data(read_data), .buffer_full_n(buffer_full_n),
    .buffer_empty_n(buffer_empty_n), .half_level_n(half_level_n));
  fdx_fifo_model #(.DEPTH(DEPTH)) u_fdx_fifo_model (.reset_in_n(reset_in_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .replay_n(replay_n),
    .chain_in_n(chain_in_n), .write_data(write_data), .read_data(read_data),
    .buffer_full_n(buffer_full_n), .buffer_empty_n(buffer_empty_n),
    .half_level_n(half_level_n), .rule_errs(model_errs));
  // Free-running clock at 100 MHz.
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Watchdog well beyond the thousand or so cycles the tests need.
  initial begin
    #200000;
    fails++;
    test_done();
  end
  // Verdict and end of run.
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compares one value.
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issues a command and polls busy until the pin sequence is over.
  task cmd(input int b);
    int n;
    n = 0;
    apb(1'b1, fdx_pkg::CMD_OFF, 32'h1 << b);
    do begin
      apb(1'b0, fdx_pkg::STATUS_OFF, '0);
      n++;
    end while (q[fdx_pkg::ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50) fails++;
  endtask
  function automatic logic [8:0] word(input int i);
    return 9'(i * 59 + 165);
  endfunction
  task st(input logic full, input logic empty, input logic half, input logic refd);
    apb(1'b0, fdx_pkg::STATUS_OFF, '0);
    chk("status", 32'({refd, 1'b1, half, empty, full, 1'b0}), q);
  endtask
  task wword(input int i);
    apb(1'b1, fdx_pkg::WDATA_OFF, 32'(word(i)));
    cmd(fdx_pkg::CMD_WRITE_BIT);
  endtask
  task rword(input logic [8:0] exp);
    cmd(fdx_pkg::CMD_READ_BIT);
    apb(1'b0, fdx_pkg::RDATA_OFF, '0);
    chk("rdata", 32'(exp), q);
  endtask
  task pins(input logic [4:0] exp);
    repeat (2) @(posedge pclk);
    chk("pins", 32'(exp),
      32'({reset_in_n, write_strobe_n, read_strobe_n, replay_n, chain_in_n}));
  endtask
  // Idle pins, and a write before any device reset is refused.
  task t_power;
    pins(5'b11110);
    wword(1);
    apb(1'b0, fdx_pkg::STATUS_OFF, '0);
    chk("refused", 32'h1, 32'(q[fdx_pkg::ST_REFUSED_BIT]));
    cmd(fdx_pkg::CMD_CLEAR_BIT);
  endtask
  // Register readback, write-only command and an unmapped address.
  task t_regs;
    apb(1'b1, fdx_pkg::WDATA_OFF, 32'hffff_ffff);
    apb(1'b0, fdx_pkg::WDATA_OFF, '0);
    chk("wdata", 32'h1ff, q);
    apb(1'b0, fdx_pkg::CMD_OFF, '0);
    chk("cmd", 32'h0, q);
    chk("slverr ok", 32'h0, 32'(e));
    apb(1'b0, 8'h14, '0);
    chk("slverr", 32'h1, 32'(e));
    chk("unmapped", 32'h0, q);
  endtask
  // A command in the settle wait after a device reset is refused and leaves the pins alone.
  task t_busy;
    apb(1'b1, fdx_pkg::CMD_OFF, 32'h1 << fdx_pkg::CMD_RESET_BIT);
    apb(1'b1, fdx_pkg::CMD_OFF, 32'h1 << fdx_pkg::CMD_READ_BIT);
    repeat (20) @(posedge pclk);
    st(1'b0, 1'b1, 1'b0, 1'b1);
    cmd(fdx_pkg::CMD_CLEAR_BIT);
  endtask
  // Fill until refused, then drain in order until reads are refused.
  task t_fill;
    cmd(fdx_pkg::CMD_RESET_BIT);
    st(1'b0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      wword(i);
      st(i == DEPTH - 1, 1'b0, i >= DEPTH / 2, 1'b0);
    end
    wword(DEPTH);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    cmd(fdx_pkg::CMD_CLEAR_BIT);
    for (int i = 0; i < DEPTH; i++) begin
      rword(word(i));
      st(1'b0, i == DEPTH - 1, i < DEPTH / 2 - 1, 1'b0);
    end
    cmd(fdx_pkg::CMD_READ_BIT);
    st(1'b0, 1'b1, 1'b0, 1'b1);
    apb(1'b0, fdx_pkg::RDATA_OFF, '0);
    chk("rdata kept", 32'(word(DEPTH - 1)), q);
    cmd(fdx_pkg::CMD_CLEAR_BIT);
  endtask
  // Replay rewinds reads only and the half flag follows the pointers.
  task t_replay;
    cmd(fdx_pkg::CMD_RESET_BIT);
    for (int i = 0; i < 5; i++) wword(i);
    rword(word(0));
    rword(word(1));
    st(1'b0, 1'b0, 1'b0, 1'b0);
    cmd(fdx_pkg::CMD_REPLAY_BIT);
    st(1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) rword(word(i));
    st(1'b0, 1'b1, 1'b0, 1'b0);
  endtask
  // Chain mode pins, and replay refused while chained.
  task t_chain;
    apb(1'b1, fdx_pkg::CTRL_OFF, 32'h1);
    pins(5'b11111);
    apb(1'b1, fdx_pkg::CTRL_OFF, 32'h3);
    pins(5'b11101);
    cmd(fdx_pkg::CMD_REPLAY_BIT);
    chk("replay refused", 32'h1, 32'(q[fdx_pkg::ST_REFUSED_BIT]));
    apb(1'b1, fdx_pkg::CTRL_OFF, 32'h0);
    pins(5'b11110);
    cmd(fdx_pkg::CMD_CLEAR_BIT);
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_power();
    t_regs();
    t_fill();
    t_busy();
    t_replay();
    t_chain();
    chk("pin protocol", 32'h0, 32'(model_errs));
    test_done();
  end
endmodule // tb_top
